// *** hdl/pmx_pkg.sv ***
package pmx_pkg;

   // Register bus geometry: each register index is one 32-bit word.
   localparam int unsigned ADR_W = 10;
   localparam int unsigned IDX_W = 8;
   localparam int unsigned IDX_LSB = 2;

   // Register indices; the byte address is four times the index.
   localparam logic [IDX_W-1:0] IDX_VID_BASE  = 8'h08;
   localparam logic [IDX_W-1:0] IDX_VID_SIZE  = 8'h09;
   localparam logic [IDX_W-1:0] IDX_STATUS    = 8'h0a;
   localparam logic [IDX_W-1:0] IDX_PATH_CTL  = 8'h11;
   localparam logic [IDX_W-1:0] IDX_MAP_SEL   = 8'h12;
   localparam logic [IDX_W-1:0] IDX_MAP_BASE  = 8'h14;
   localparam logic [IDX_W-1:0] IDX_MAP_WIDTH = 8'h18;
   localparam logic [IDX_W-1:0] IDX_MAP_FMT   = 8'h1c;
   localparam logic [IDX_W-1:0] IDX_MAP_HGT   = 8'h20;
   localparam logic [IDX_W-1:0] IDX_FG_MIX    = 8'h48;
   localparam logic [IDX_W-1:0] IDX_BG_MIX    = 8'h49;
   localparam logic [IDX_W-1:0] IDX_DST_CMP   = 8'h4a;
   localparam logic [IDX_W-1:0] IDX_PLANE_MSK = 8'h50;
   localparam logic [IDX_W-1:0] IDX_CARRY_MSK = 8'h54;
   localparam logic [IDX_W-1:0] IDX_FG_COLOR  = 8'h58;
   localparam logic [IDX_W-1:0] IDX_BG_COLOR  = 8'h5c;
   localparam logic [IDX_W-1:0] IDX_OP_WIDTH  = 8'h60;
   localparam logic [IDX_W-1:0] IDX_OP_HGT    = 8'h62;
   localparam logic [IDX_W-1:0] IDX_DST_X     = 8'h78;
   localparam logic [IDX_W-1:0] IDX_DST_Y     = 8'h7a;
   localparam logic [IDX_W-1:0] IDX_PIX_OP    = 8'h7c;

   // Map selector values.
   localparam logic [3:0] MAP_MASK  = 4'h0;
   localparam logic [3:0] MAP_C     = 4'h3;
   localparam int unsigned NUM_MAPS = 4;

   // Format code layout: bit 3 is byte order, bits 1:0 give log2 depth.
   localparam int unsigned FMT_ORDER_BIT = 3;
   localparam logic [7:0]  FMT_CODE_MASK = 8'hf4;

   // Mix codes.
   localparam logic [7:0] MIX_LOGIC_LAST = 8'h0f;
   localparam logic [7:0] MIX_MAX        = 8'h10;
   localparam logic [7:0] MIX_MIN        = 8'h11;
   localparam logic [7:0] MIX_ADD_SAT    = 8'h12;
   localparam logic [7:0] MIX_D_MINUS_S  = 8'h13;
   localparam logic [7:0] MIX_S_MINUS_D  = 8'h14;
   localparam logic [7:0] MIX_AVERAGE    = 8'h15;

   localparam logic [7:0] CMP_NO_EFFECT  = 8'h04;

   // Pixel operation word fields.
   localparam int unsigned OP_BG_SRC_HI = 31;
   localparam int unsigned OP_FG_SRC_HI = 29;
   localparam int unsigned OP_SRC_MAP_LO = 20;
   localparam int unsigned OP_DST_MAP_LO = 16;
   localparam logic [1:0]  SRC_FROM_MAP  = 2'b10;

   // Status bit positions.
   localparam int unsigned ST_FMT_LO   = 4;
   localparam int unsigned ST_FG_MIX   = 8;
   localparam int unsigned ST_BG_MIX   = 9;
   localparam int unsigned ST_CMP_OFF  = 10;

endpackage

// *** hdl/pmx_regs.sv ***
`timescale 1ns/1ps

// Overview of operation
// R1 - Four pixel maps, each fully described
// R2 - Four-bit selector: mask, A, B, C
// R3 - Map base is full 32-bit byte address
// R4 - Base inside video window means video memory
// R5 - Host keeps system maps below 16 MB
// R6 - Map width stored as pixels minus one
// R7 - Map height stored as rows minus one
// R8 - Format codes give depth and byte order
// R9 - Maps A, B, C interchangeable per operation
// R10 - Mix codes 0-F are bitwise functions
// R11 - Mix codes 10-15 are arithmetic functions
// R12 - Pattern picks foreground or background mix
// R13 - Color registers supply fixed source pixels
// R14 - Map-sourced transfers ignore color registers
// R15 - Operation width is pixel count minus one
// R16 - Operation height is row count minus one
// R17 - Software clears path control before launch
// R18 - Compare code 04h disables destination compare
// R19 - Plane mask bits enable destination planes
// R20 - Software sets carry mask bits for depth
// R21 - 32-bit pixel operation word held
// R22 - Destination X and Y offsets held
// R23 - Map writes and reads follow selector
// R24 - Setup registers hold until rewritten
module pmx_regs (
   input  wire  logic                         mclk,
   input  wire  logic                         rst_n,
   input  wire  logic                         wb_cyc_i,
   input  wire  logic                         wb_stb_i,
   input  wire  logic                         wb_we_i,
   input  wire  logic [pmx_pkg::ADR_W-1:0]    wb_adr_i,
   input  wire  logic [3:0]                   wb_sel_i,
   input  wire  logic [31:0]                  wb_dat_i,
   output logic       [31:0]                  wb_dat_o,
   output logic                               wb_ack_o,
   input  wire  logic                         px_valid_i,
   input  wire  logic [7:0]                   px_src_i,
   input  wire  logic [7:0]                   px_dst_i,
   input  wire  logic                         px_pattern_i,
   output logic                               px_valid_o,
   output logic       [7:0]                   px_result_o,
   output logic       [7:0]                   px_plane_mask_o,
   output logic                               cmp_active_o,
   output logic       [31:0]                  pix_op_o,
   output logic       [7:0]                   path_ctl_o,
   output logic       [7:0]                   carry_mask_o,
   output logic       [16:0]                  op_width_px_o,
   output logic       [16:0]                  op_height_px_o,
   output logic       [15:0]                  dst_x_o,
   output logic       [15:0]                  dst_y_o,
   output logic       [31:0]                  src_base_o,
   output logic       [16:0]                  src_width_px_o,
   output logic       [16:0]                  src_height_px_o,
   output logic       [1:0]                   src_bpp_log2_o,
   output logic                               src_big_endian_o,
   output logic                               src_in_video_o,
   output logic       [31:0]                  dst_base_o,
   output logic       [16:0]                  dst_width_px_o,
   output logic       [16:0]                  dst_height_px_o,
   output logic       [1:0]                   dst_bpp_log2_o,
   output logic                               dst_big_endian_o,
   output logic                               dst_in_video_o
);
   import pmx_pkg::*;

   typedef struct packed {
      logic                         ack;
      logic [31:0]                  rdata;
      logic [7:0]                   path_ctl;
      logic [3:0]                   map_sel;
      logic [NUM_MAPS-1:0][31:0]    base;
      logic [NUM_MAPS-1:0][15:0]    wid;
      logic [NUM_MAPS-1:0][15:0]    hgt;
      logic [NUM_MAPS-1:0][7:0]     fmt;
      logic [7:0]                   fg_mix;
      logic [7:0]                   bg_mix;
      logic [7:0]                   cmp;
      logic [15:0]                  plane;
      logic [7:0]                   carry;
      logic [7:0]                   fg_col;
      logic [7:0]                   bg_col;
      logic [15:0]                  op_w;
      logic [15:0]                  op_h;
      logic [15:0]                  dst_x;
      logic [15:0]                  dst_y;
      logic [31:0]                  pix_op;
      logic [31:0]                  vid_base;
      logic [31:0]                  vid_size;
      logic [7:0]                   px_res;
      logic                         px_vld;
   } pmx_state_t;

   pmx_state_t state_reg;
   pmx_state_t state_next;

   logic [IDX_W-1:0] idx;
   logic             req;
   logic             wr;
   logic             sel_ok;
   logic [1:0]       sel_map;
   logic [1:0]       src_map;
   logic [1:0]       dst_map;
   logic [NUM_MAPS-1:0] in_video;
   logic [NUM_MAPS-1:0] fmt_ok;
   logic [31:0]      status;

   // Byte-lane merge so partial writes only touch the selected lanes.
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  lanes);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (lanes[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // The window is taken as [base, base + size); the sum is 33 bits so a
   // window that reaches the top of the address space does not wrap.
   function automatic logic video_hit(input logic [31:0] addr,
                                      input logic [31:0] vbase,
                                      input logic [31:0] vsize);
      logic [32:0] top;
      top = {1'b0, vbase} + {1'b0, vsize};
      return (addr >= vbase) && ({1'b0, addr} < top);
   endfunction

   // One mix applied to a pixel; unknown codes leave the destination.
   function automatic logic [7:0] mix_px(input logic [7:0] code,
                                         input logic [7:0] s,
                                         input logic [7:0] d);
      logic [8:0] t;
      logic [7:0] r;
      t = '0;
      r = d;
      if (code <= MIX_LOGIC_LAST) begin
         // Each code is its own truth table indexed by the inverted bits.
         for (int b = 0; b < 8; b++) begin
            r[b] = code[{~s[b], ~d[b]}]; // R10
         end
      end else begin
         case (code) // R11
            MIX_MAX:       r = (s > d) ? s : d;
            MIX_MIN:       r = (s < d) ? s : d;
            MIX_ADD_SAT: begin
               t = {1'b0, s} + {1'b0, d};
               r = t[8] ? 8'hff : t[7:0];
            end
            MIX_D_MINUS_S: r = (d > s) ? d - s : 8'h00;
            MIX_S_MINUS_D: r = (s > d) ? s - d : 8'h00;
            MIX_AVERAGE: begin
               t = {1'b0, s} + {1'b0, d};
               r = t[8:1];
            end
            default:       r = d;
         endcase
      end
      return r;
   endfunction

   // Bus decode and selector-driven map addressing.
   assign idx     = wb_adr_i[IDX_LSB +: IDX_W];
   assign req     = wb_cyc_i && wb_stb_i && !state_reg.ack;
   assign wr      = req && wb_we_i;
   assign sel_ok  = state_reg.map_sel <= MAP_C; // R2
   assign sel_map = state_reg.map_sel[1:0];
   assign src_map = state_reg.pix_op[OP_SRC_MAP_LO +: 2];
   assign dst_map = state_reg.pix_op[OP_DST_MAP_LO +: 2];

   // Per-map derived state: location and format legality.
   always_comb begin
      for (int m = 0; m < NUM_MAPS; m++) begin
         in_video[m] = video_hit(state_reg.base[m], state_reg.vid_base,
                                 state_reg.vid_size); // R4
         fmt_ok[m]   = (state_reg.fmt[m] & FMT_CODE_MASK) == 8'h00; // R8
      end
      status = '0;
      status[NUM_MAPS-1:0]             = in_video;
      status[ST_FMT_LO +: NUM_MAPS]    = fmt_ok;
      status[ST_FG_MIX] = state_reg.fg_mix <= MIX_AVERAGE;
      status[ST_BG_MIX] = state_reg.bg_mix <= MIX_AVERAGE;
      status[ST_CMP_OFF] = state_reg.cmp == CMP_NO_EFFECT;
   end

   // Next state: bus answer, register writes, and the pixel mix stage.
   always_comb begin
      logic [31:0] m;
      logic [7:0]  fg_s;
      logic [7:0]  bg_s;
      m = '0;
      fg_s = '0;
      bg_s = '0;
      state_next = state_reg;
      state_next.ack = req;
      if (req && !wb_we_i) begin
         case (idx)
            IDX_VID_BASE:  state_next.rdata = state_reg.vid_base;
            IDX_VID_SIZE:  state_next.rdata = state_reg.vid_size;
            IDX_STATUS:    state_next.rdata = status;
            IDX_PATH_CTL:  state_next.rdata = {24'h0, state_reg.path_ctl};
            IDX_MAP_SEL:   state_next.rdata = {28'h0, state_reg.map_sel};
            IDX_MAP_BASE:  state_next.rdata = sel_ok ?
                              state_reg.base[sel_map] : 32'h0; // R23
            IDX_MAP_WIDTH: state_next.rdata = sel_ok ?
                              {16'h0, state_reg.wid[sel_map]} : 32'h0;
            IDX_MAP_FMT:   state_next.rdata = sel_ok ?
                              {24'h0, state_reg.fmt[sel_map]} : 32'h0;
            IDX_MAP_HGT:   state_next.rdata = sel_ok ?
                              {16'h0, state_reg.hgt[sel_map]} : 32'h0;
            IDX_FG_MIX:    state_next.rdata = {24'h0, state_reg.fg_mix};
            IDX_BG_MIX:    state_next.rdata = {24'h0, state_reg.bg_mix};
            IDX_DST_CMP:   state_next.rdata = {24'h0, state_reg.cmp};
            IDX_PLANE_MSK: state_next.rdata = {16'h0, state_reg.plane};
            IDX_CARRY_MSK: state_next.rdata = {24'h0, state_reg.carry};
            IDX_FG_COLOR:  state_next.rdata = {24'h0, state_reg.fg_col};
            IDX_BG_COLOR:  state_next.rdata = {24'h0, state_reg.bg_col};
            IDX_OP_WIDTH:  state_next.rdata = {16'h0, state_reg.op_w};
            IDX_OP_HGT:    state_next.rdata = {16'h0, state_reg.op_h};
            IDX_DST_X:     state_next.rdata = {16'h0, state_reg.dst_x};
            IDX_DST_Y:     state_next.rdata = {16'h0, state_reg.dst_y};
            IDX_PIX_OP:    state_next.rdata = state_reg.pix_op;
            default:       state_next.rdata = 32'h0;
         endcase
      end
      // Registers only change here, so every value holds until rewritten.
      if (wr) begin // R24
         case (idx)
            IDX_VID_BASE: state_next.vid_base =
               merge(state_reg.vid_base, wb_dat_i, wb_sel_i);
            IDX_VID_SIZE: state_next.vid_size =
               merge(state_reg.vid_size, wb_dat_i, wb_sel_i);
            IDX_PATH_CTL: begin
               m = merge({24'h0, state_reg.path_ctl}, wb_dat_i, wb_sel_i);
               state_next.path_ctl = m[7:0];
            end
            IDX_MAP_SEL: begin
               m = merge({28'h0, state_reg.map_sel}, wb_dat_i, wb_sel_i);
               state_next.map_sel = m[3:0]; // R2
            end
            IDX_MAP_BASE: if (sel_ok) begin
               state_next.base[sel_map] =
                  merge(state_reg.base[sel_map], wb_dat_i, wb_sel_i); // R3 R23
            end
            IDX_MAP_WIDTH: if (sel_ok) begin
               m = merge({16'h0, state_reg.wid[sel_map]}, wb_dat_i, wb_sel_i);
               state_next.wid[sel_map] = m[15:0]; // R23
            end
            IDX_MAP_FMT: if (sel_ok) begin
               m = merge({24'h0, state_reg.fmt[sel_map]}, wb_dat_i, wb_sel_i);
               state_next.fmt[sel_map] = m[7:0]; // R23
            end
            IDX_MAP_HGT: if (sel_ok) begin
               m = merge({16'h0, state_reg.hgt[sel_map]}, wb_dat_i, wb_sel_i);
               state_next.hgt[sel_map] = m[15:0]; // R23
            end
            IDX_FG_MIX: begin
               m = merge({24'h0, state_reg.fg_mix}, wb_dat_i, wb_sel_i);
               state_next.fg_mix = m[7:0];
            end
            IDX_BG_MIX: begin
               m = merge({24'h0, state_reg.bg_mix}, wb_dat_i, wb_sel_i);
               state_next.bg_mix = m[7:0];
            end
            IDX_DST_CMP: begin
               m = merge({24'h0, state_reg.cmp}, wb_dat_i, wb_sel_i);
               state_next.cmp = m[7:0];
            end
            IDX_PLANE_MSK: begin
               m = merge({16'h0, state_reg.plane}, wb_dat_i, wb_sel_i);
               state_next.plane = m[15:0];
            end
            IDX_CARRY_MSK: begin
               m = merge({24'h0, state_reg.carry}, wb_dat_i, wb_sel_i);
               state_next.carry = m[7:0];
            end
            IDX_FG_COLOR: begin
               m = merge({24'h0, state_reg.fg_col}, wb_dat_i, wb_sel_i);
               state_next.fg_col = m[7:0];
            end
            IDX_BG_COLOR: begin
               m = merge({24'h0, state_reg.bg_col}, wb_dat_i, wb_sel_i);
               state_next.bg_col = m[7:0];
            end
            IDX_OP_WIDTH: begin
               m = merge({16'h0, state_reg.op_w}, wb_dat_i, wb_sel_i);
               state_next.op_w = m[15:0];
            end
            IDX_OP_HGT: begin
               m = merge({16'h0, state_reg.op_h}, wb_dat_i, wb_sel_i);
               state_next.op_h = m[15:0];
            end
            IDX_DST_X: begin
               m = merge({16'h0, state_reg.dst_x}, wb_dat_i, wb_sel_i);
               state_next.dst_x = m[15:0]; // R22
            end
            IDX_DST_Y: begin
               m = merge({16'h0, state_reg.dst_y}, wb_dat_i, wb_sel_i);
               state_next.dst_y = m[15:0]; // R22
            end
            IDX_PIX_OP: state_next.pix_op =
               merge(state_reg.pix_op, wb_dat_i, wb_sel_i); // R21
            default: ;
         endcase
      end
      // Fixed colors feed the mix unless the source field points at a map.
      fg_s = (state_reg.pix_op[OP_FG_SRC_HI -: 2] == SRC_FROM_MAP) ?
             px_src_i : state_reg.fg_col; // R13 R14
      bg_s = (state_reg.pix_op[OP_BG_SRC_HI -: 2] == SRC_FROM_MAP) ?
             px_src_i : state_reg.bg_col; // R13 R14
      state_next.px_vld = px_valid_i;
      if (px_valid_i) begin
         state_next.px_res = px_pattern_i ?
            mix_px(state_reg.fg_mix, fg_s, px_dst_i) :
            mix_px(state_reg.bg_mix, bg_s, px_dst_i); // R12
      end
   end

   // Single register stage for all state.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // Outputs; map views are picked by the operation word fields.
   assign wb_ack_o         = state_reg.ack;
   assign wb_dat_o         = state_reg.rdata;
   assign px_valid_o       = state_reg.px_vld;
   assign px_result_o      = state_reg.px_res;
   assign px_plane_mask_o  = state_reg.plane[7:0]; // R19
   assign cmp_active_o     = state_reg.cmp != CMP_NO_EFFECT; // R18
   assign pix_op_o         = state_reg.pix_op;
   assign path_ctl_o       = state_reg.path_ctl;
   assign carry_mask_o     = state_reg.carry;
   assign op_width_px_o    = {1'b0, state_reg.op_w} + 17'h1; // R15
   assign op_height_px_o   = {1'b0, state_reg.op_h} + 17'h1; // R16
   assign dst_x_o          = state_reg.dst_x;
   assign dst_y_o          = state_reg.dst_y;
   assign src_base_o       = state_reg.base[src_map]; // R1 R9
   assign src_width_px_o   = {1'b0, state_reg.wid[src_map]} + 17'h1; // R6
   assign src_height_px_o  = {1'b0, state_reg.hgt[src_map]} + 17'h1; // R7
   assign src_bpp_log2_o   = state_reg.fmt[src_map][1:0]; // R8
   assign src_big_endian_o = state_reg.fmt[src_map][FMT_ORDER_BIT];
   assign src_in_video_o   = in_video[src_map];
   assign dst_base_o       = state_reg.base[dst_map]; // R9
   assign dst_width_px_o   = {1'b0, state_reg.wid[dst_map]} + 17'h1; // R6
   assign dst_height_px_o  = {1'b0, state_reg.hgt[dst_map]} + 17'h1; // R7
   assign dst_bpp_log2_o   = state_reg.fmt[dst_map][1:0]; // R8
   assign dst_big_endian_o = state_reg.fmt[dst_map][FMT_ORDER_BIT];
   assign dst_in_video_o   = in_video[dst_map];

   // Checks on the answers this block drives.
   ack_pulse_a: assert property (@(posedge mclk) disable iff (!rst_n)
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not a single pulse one cycle after request");
   sel_write_a: assert property (@(posedge mclk) disable iff (!rst_n) // R23
      wr && idx == IDX_MAP_BASE && sel_ok && wb_sel_i == 4'hf
      |=> state_reg.base[$past(sel_map)] == $past(wb_dat_i))
      else $error("base write did not reach selected map");
   hold_maps_a: assert property (@(posedge mclk) disable iff (!rst_n) // R24
      !wr |=> $stable(state_reg.base) && $stable(state_reg.fmt))
      else $error("map definition changed without a write");
   bad_sel_a: assert property (@(posedge mclk) disable iff (!rst_n) // R2
      req && !wb_we_i && idx == IDX_MAP_BASE && !sel_ok
      |=> wb_ack_o && wb_dat_o == 32'h0)
      else $error("base read with out-of-range selector not zero");
   video_loc_a: assert property (@(posedge mclk) disable iff (!rst_n) // R4
      state_reg.vid_size == 32'h0 |-> !dst_in_video_o)
      else $error("map in empty video window");
   cmp_off_a: assert property (@(posedge mclk) disable iff (!rst_n) // R18
      wr && idx == IDX_DST_CMP && wb_sel_i[0] && wb_dat_i[7:0] == 8'h04
      |=> !cmp_active_o)
      else $error("compare code 04h left compare active");
   color_src_a: assert property (@(posedge mclk) disable iff (!rst_n) // R13
      px_valid_i && px_pattern_i && state_reg.fg_mix == 8'h03 &&
      state_reg.pix_op[OP_FG_SRC_HI -: 2] == 2'b00
      |=> px_valid_o && px_result_o == $past(state_reg.fg_col))
      else $error("foreground color not used as source");
   map_src_a: assert property (@(posedge mclk) disable iff (!rst_n) // R14
      px_valid_i && !px_pattern_i && state_reg.bg_mix == 8'h03 &&
      state_reg.pix_op[OP_BG_SRC_HI -: 2] == SRC_FROM_MAP
      |=> px_result_o == $past(px_src_i))
      else $error("map-sourced pixel replaced by color");
   sat_add_a: assert property (@(posedge mclk) disable iff (!rst_n) // R11
      px_valid_i && px_pattern_i && state_reg.fg_mix == 8'h12 &&
      px_dst_i == 8'hff |=> px_result_o == 8'hff)
      else $error("saturating add wrapped");

endmodule // pmx_regs

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
   import pmx_pkg::*;
   logic        mclk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0;
   logic        pv = 0, pp = 0, ack, pvo, cmp, dbe, div;
   logic [9:0]  adr = '0;
   logic [31:0] wd = '0, rd, q, dbase;
   logic [7:0]  ps = '0, pd = '0, pr, pmask;
   logic [16:0] opw, oph, dw, dh;
   logic [1:0]  dbpp, sbpp;
   logic [31:0] po, sb;
   logic [16:0] sw, sh;
   logic [15:0] dx, dy;
   logic [7:0]  pc, cm;
   logic        sbe, siv;
   int          num_errors = 0, n_tests = 0, cyc_cnt = 0;

   // The clock inverts every half period of 12.5 ns.
   always #12.5 mclk = ~mclk;

   // Byte enables stay all on, since every write here is a full word.
   pmx_regs pmx_regs_i (
      .mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd),
      .wb_dat_o(rd), .wb_ack_o(ack), .px_valid_i(pv), .px_src_i(ps),
      .px_dst_i(pd), .px_pattern_i(pp), .px_valid_o(pvo),
      .px_result_o(pr), .px_plane_mask_o(pmask), .cmp_active_o(cmp),
      .pix_op_o(po), .path_ctl_o(pc), .carry_mask_o(cm),
      .op_width_px_o(opw), .op_height_px_o(oph), .dst_x_o(dx),
      .dst_y_o(dy), .src_base_o(sb), .src_width_px_o(sw),
      .src_height_px_o(sh), .src_bpp_log2_o(sbpp),
      .src_big_endian_o(sbe), .src_in_video_o(siv), .dst_base_o(dbase),
      .dst_width_px_o(dw), .dst_height_px_o(dh), .dst_bpp_log2_o(dbpp),
      .dst_big_endian_o(dbe), .dst_in_video_o(div));

   task automatic finish_test();
      if (num_errors == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, g);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One classic cycle; the request holds until ack is sampled high.
   task automatic bus(input logic w, input logic [7:0] i,
                      input logic [31:0] d);
      @(posedge mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {i, 2'b00};
      wd <= d;
      do @(posedge mclk); while (ack !== 1'b1);
      q = rd;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic rdc(input string nm, input logic [7:0] i,
                      input logic [31:0] e);
      bus(1'b0, i, 32'h0);
      chk(nm, e, q);
   endtask

   // The result is looked at just after the edge that raises it.
   task automatic pix(input logic p, input logic [7:0] s, d, e);
      @(posedge mclk);
      pv <= 1'b1;
      pp <= p;
      ps <= s;
      pd <= d;
      @(posedge mclk);
      pv <= 1'b0;
      #1 chk("px_valid", 32'h1, pvo);
      chk("px_result", e, pr);
   endtask

   // Expected mix, each of the sixteen logic functions written out.
   function automatic logic [7:0] mix(input logic [7:0] c, s, d);
      logic [8:0] t;
      t = 9'(s) + 9'(d);
      case (c)
         8'h00: return 8'h00;
         8'h01: return s & d;
         8'h02: return s & ~d;
         8'h03: return s;
         8'h04: return ~s & d;
         8'h05: return d;
         8'h06: return s ^ d;
         8'h07: return s | d;
         8'h08: return ~s & ~d;
         8'h09: return s ^ ~d;
         8'h0a: return ~d;
         8'h0b: return s | ~d;
         8'h0c: return ~s;
         8'h0d: return ~s | d;
         8'h0e: return ~s | ~d;
         8'h0f: return 8'hff;
         8'h10: return (s > d) ? s : d;
         8'h11: return (s < d) ? s : d;
         8'h12: return t[8] ? 8'hff : t[7:0];
         8'h13: return (d > s) ? d - s : 8'h00;
         8'h14: return (s > d) ? s - d : 8'h00;
         8'h15: return t[8:1];
         default: return d;
      endcase
   endfunction

   // A hang is cut short well beyond the few hundred cycles needed.
   always @(posedge mclk) begin
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         num_errors++;
         finish_test();
      end
   end

   // Main sequence.
   initial begin
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      #1 chk("op_width_rst", 32'd1, opw);
      for (int m = 0; m < 4; m++) begin
         bus(1'b1, IDX_MAP_SEL, m);
         bus(1'b1, IDX_MAP_BASE, (32'(m) << 28) | 32'h80);
         bus(1'b1, IDX_MAP_WIDTH, 32'h27f + m);
         bus(1'b1, IDX_MAP_FMT, m | (m[0] ? 8 : 0));
         bus(1'b1, IDX_MAP_HGT, 32'h1df + m);
      end
      for (int m = 0; m < 4; m++) begin
         bus(1'b1, IDX_MAP_SEL, m);
         rdc("map_base", IDX_MAP_BASE, (32'(m) << 28) | 32'h80);
         rdc("map_width", IDX_MAP_WIDTH, 32'h27f + m);
      end
      bus(1'b1, IDX_MAP_SEL, 32'h5);
      rdc("map_base_sel5", IDX_MAP_BASE, 32'h0);
      rdc("unmapped", 8'h01, 32'h0);
      // Maps A to C lie in the video window, so the only system-memory map
      // is the mask map, which stays below the 16 MB line.
      bus(1'b1, IDX_VID_BASE, 32'h1000_0000);
      bus(1'b1, IDX_VID_SIZE, 32'h3000_0000);
      for (int m = 1; m < 4; m++) begin
         bus(1'b1, IDX_PIX_OP, (32'(m) << 20) | (32'(m) << 16));
         chk("pix_op", (32'(m) << 20) | (32'(m) << 16), po);
         chk("src_base", (32'(m) << 28) | 32'h80, sb);
         chk("src_width", 32'h280 + m, sw);
         chk("src_height", 32'h1e0 + m, sh);
         chk("src_fmt", {m[1:0], m[0], 1'b1}, {sbpp, sbe, siv});
         chk("dst_base", (32'(m) << 28) | 32'h80, dbase);
         chk("dst_width", 32'h280 + m, dw);
         chk("dst_height", 32'h1e0 + m, dh);
         chk("dst_bpp", m & 3, dbpp);
         chk("dst_order", m & 1, dbe);
      end
      chk("in_video", 32'h1, div);
      bus(1'b1, IDX_VID_SIZE, 32'h2000_0080);
      chk("in_video_edge", 32'h0, div);
      bus(1'b1, IDX_OP_WIDTH, 32'h63);
      bus(1'b1, IDX_OP_HGT, 32'h3b);
      chk("op_width", 32'd100, opw);
      chk("op_height", 32'd60, oph);
      bus(1'b1, IDX_DST_CMP, 32'h04);
      chk("cmp_off", 32'h0, cmp);
      bus(1'b1, IDX_DST_CMP, 32'h05);
      chk("cmp_on", 32'h1, cmp);
      bus(1'b1, IDX_PLANE_MSK, 32'hff);
      chk("plane_mask", 32'hff, pmask);
      bus(1'b1, IDX_PATH_CTL, 32'ha5);
      chk("path_ctl", 32'ha5, pc);
      bus(1'b1, IDX_PATH_CTL, 32'h00);
      chk("path_ctl_clr", 32'h0, pc);
      bus(1'b1, IDX_CARRY_MSK, 32'hff);
      chk("carry_mask", 32'hff, cm);
      bus(1'b1, IDX_DST_X, 32'hc8);
      bus(1'b1, IDX_DST_Y, 32'h96);
      chk("dst_xy", 32'h00c8_0096, {dx, dy});
      bus(1'b1, IDX_FG_COLOR, 32'h05);
      bus(1'b1, IDX_BG_COLOR, 32'h3c);
      bus(1'b1, IDX_PIX_OP, 32'h2000_0000);
      for (int c = 0; c < 22; c++) begin
         bus(1'b1, IDX_FG_MIX, c);
         bus(1'b1, IDX_BG_MIX, 21 - c);
         pix(1'b1, 8'h5a, 8'hc3, mix(8'(c), 8'h5a, 8'hc3));
         pix(1'b0, 8'h5a, 8'hc3, mix(8'(21 - c), 8'h3c, 8'hc3));
      end
      // Background taken from the map; saturation reached on a white pixel.
      bus(1'b1, IDX_PIX_OP, 32'h8000_0000);
      bus(1'b1, IDX_BG_MIX, 32'h03);
      pix(1'b0, 8'h5a, 8'hc3, 8'h5a);
      bus(1'b1, IDX_FG_MIX, 32'h12);
      pix(1'b1, 8'h01, 8'hff, 8'hff);
      bus(1'b1, IDX_PIX_OP, 32'h0);
      bus(1'b1, IDX_FG_MIX, 32'h03);
      pix(1'b1, 8'h5a, 8'hc3, 8'h05);
      rdc("op_width_hold", IDX_OP_WIDTH, 32'h63);
      finish_test();
   end
endmodule // tb_top
